/* verilog/synth_freq_pkg.sv */
// Constants, register map and sequencer states for synthesizer control
package synth_freq_pkg;

  // Register addresses
  localparam logic [6:0] ADDR_OFS_LO  = 7'h73;
  localparam logic [6:0] ADDR_OFS_HI  = 7'h74;
  localparam logic [6:0] ADDR_BAND    = 7'h75;
  localparam logic [6:0] ADDR_FRAC_HI = 7'h76;
  localparam logic [6:0] ADDR_FRAC_LO = 7'h77;
  localparam logic [6:0] ADDR_HOP_CH  = 7'h79;
  localparam logic [6:0] ADDR_HOP_STP = 7'h7a;

  // Reset values
  localparam logic [7:0] RST_OFS_LO  = 8'h00;
  localparam logic [7:0] RST_OFS_HI  = 8'h00;
  localparam logic [7:0] RST_BAND    = 8'h35;
  localparam logic [7:0] RST_FRAC_HI = 8'hbb;
  localparam logic [7:0] RST_FRAC_LO = 8'h80;
  localparam logic [7:0] RST_HOP_CH  = 8'h00;
  localparam logic [7:0] RST_HOP_STP = 8'h00;

  // Field positions inside band_select, and width of the high offset register
  localparam int BAND_HB_BIT   = 5;
  localparam int BAND_SB_BIT   = 6;
  localparam int OFS_HI_WIDTH  = 2;

  // Division arithmetic
  localparam logic [4:0]  BAND_INT_MAX = 5'h17;
  localparam logic [7:0]  N_OFFSET   = 8'h18;
  localparam logic [24:0] FRAC_MOD   = 25'h000_fa00;
  // Loop LSB is 156.25 Hz, doubled in high band: 10 kHz, 625 Hz in LSBs
  localparam logic [6:0]  HOP_UNIT_LB = 7'h40;
  localparam logic [6:0]  HOP_UNIT_HB = 7'h20;
  localparam logic [2:0]  DEV_UNIT_LB = 3'h4;
  localparam logic [2:0]  DEV_UNIT_HB = 3'h2;

  // Sequencer timing
  localparam int CLK_NS    = 50;
  localparam int CAL_NS    = 100000;
  localparam int SETTLE_NS = 100000;
  localparam int CAL_CYC    = (CAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_CAL,
    ST_SETTLE,
    ST_TUNE,
    ST_TX
  } seq_state_t;

endpackage

/* verilog/sdm_if.sv */
// Interface between sequencer and fractional modulator
`timescale 1ns/10ps
interface sdm_if;
  logic [15:0] frac;
  logic [7:0]  int_n;
  logic        run;
  logic        step;
  logic [7:0]  div_n;

  modport ctl (output frac, output int_n, output run, output step,
               input div_n);
  modport sdm (input frac, input int_n, input run, input step,
               output div_n);
endinterface

/* verilog/sdm_mash3.sv */
// Third-order cascaded fractional modulator with modulo accumulators
`timescale 1ns/10ps
module sdm_mash3 #(
  parameter int FRAC_W = 16
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  sdm_if.sdm        bus
);

  localparam logic [16:0] MOD = 17'(synth_freq_pkg::FRAC_MOD);

  // Elaboration check: the fraction port must hold the whole modulus
  if ((1 << FRAC_W) < int'(synth_freq_pkg::FRAC_MOD))
  begin
    $error("FRAC_W too narrow for modulus");
  end

  logic [16:0] acc1_q, acc2_q, acc3_q;
  logic [16:0] s1, s2, s3;
  logic        c1, c2, c3;
  logic        c2_q, c3_q, c3_qq;
  logic [7:0]  div_q;
  logic signed [3:0] y;

  // Each stage wraps at the modulus; carry is its output bit
  always_comb
  begin
    s1 = acc1_q + 17'(bus.frac);
    c1 = (s1 >= MOD);
    if (c1)
      s1 = s1 - MOD;
    s2 = acc2_q + s1;
    c2 = (s2 >= MOD);
    if (c2)
      s2 = s2 - MOD;
    s3 = acc3_q + s2;
    c3 = (s3 >= MOD);
    if (c3)
      s3 = s3 - MOD;
    y = 4'(c1) + 4'(c2) - 4'(c2_q) + 4'(c3) - 4'(2 * c3_q) + 4'(c3_qq);
  end

  // Steps at the reference rate only; cleared to zero while the loop is off
  always_ff @(posedge clk_sys)
  begin
    if (srst || !bus.run)
    begin
      acc1_q <= '0;
      acc2_q <= '0;
      acc3_q <= '0;
      c2_q   <= 1'b0;
      c3_q   <= 1'b0;
      c3_qq  <= 1'b0;
    end
    else if (bus.step)
    begin
      acc1_q <= s1;
      acc2_q <= s2;
      acc3_q <= s3;
      c2_q   <= c2;
      c3_q   <= c3;
      c3_qq  <= c3_q;
    end
  end

  // Instantaneous feedback divide ratio
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      div_q <= '0;
    else if (bus.step)
      div_q <= bus.int_n + 8'(signed'(y));
  end

  assign bus.div_n = div_q;

  acc_wrap_a: assert property (@(posedge clk_sys) disable iff (srst)
    (bus.run && bus.step) |=> (acc1_q ==
      (($past(acc1_q) + 17'($past(bus.frac))) % MOD)))
    else $error("first accumulator did not wrap at modulus");

endmodule

/* verilog/synth_frequency_control.sv */
// Synthesizer frequency registers, division word and tune sequencer
`timescale 1ns/10ps
module synth_frequency_control (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       reg_wr,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_q,
  input  wire logic       synth_enable,
  input  wire logic       tx_enable,
  input  wire logic       fifo_mode,
  input  wire logic       packet_active,
  input  wire logic       fsk_enable,
  input  wire logic       tx_symbol,
  input  wire logic [8:0] deviation_field,
  output logic      [7:0] div_ratio_q,
  output logic            band_high_q,
  output logic            pll_on_q,
  output logic            vco_cal_q,
  output logic            tx_active_q
);

  synth_freq_pkg::seq_state_t state_q;
  logic [7:0]  offset_lo_q, offset_hi_q, band_q, frac_hi_q, frac_lo_q;
  logic [7:0]  hop_ch_q, hop_stp_q;
  logic [11:0] cnt_q;
  logic        hop_pend_q, ref_ph_q;
  logic signed [25:0] word_q, base_word, mod_word;
  logic [24:0] pos_word, quot;
  logic [7:0]  n_q;
  logic [15:0] f_q;
  logic        hop_wr, enter_cal, retune;
  sdm_if       sdm_bus ();

  // Register writes; band_integer above its range is held at 23
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      offset_lo_q <= synth_freq_pkg::RST_OFS_LO;
      offset_hi_q <= synth_freq_pkg::RST_OFS_HI;
      band_q      <= synth_freq_pkg::RST_BAND;
      frac_hi_q   <= synth_freq_pkg::RST_FRAC_HI;
      frac_lo_q   <= synth_freq_pkg::RST_FRAC_LO;
      hop_ch_q    <= synth_freq_pkg::RST_HOP_CH;
      hop_stp_q   <= synth_freq_pkg::RST_HOP_STP;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        synth_freq_pkg::ADDR_OFS_LO:  offset_lo_q <= reg_wdata;
        synth_freq_pkg::ADDR_OFS_HI:
          offset_hi_q <= {6'h00, reg_wdata[1:0]};
        synth_freq_pkg::ADDR_BAND:
        begin
          band_q[7:5] <= {1'b0, reg_wdata[6:5]};
          band_q[4:0] <= (reg_wdata[4:0] > synth_freq_pkg::BAND_INT_MAX)
                         ? synth_freq_pkg::BAND_INT_MAX
                         : reg_wdata[4:0];
        end
        synth_freq_pkg::ADDR_FRAC_HI: frac_hi_q <= reg_wdata;
        synth_freq_pkg::ADDR_FRAC_LO: frac_lo_q <= reg_wdata;
        synth_freq_pkg::ADDR_HOP_CH:  hop_ch_q  <= reg_wdata;
        synth_freq_pkg::ADDR_HOP_STP: hop_stp_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      reg_rdata_q <= 8'h00;
    else
    begin
      unique case (reg_addr)
        synth_freq_pkg::ADDR_OFS_LO:  reg_rdata_q <= offset_lo_q;
        synth_freq_pkg::ADDR_OFS_HI:  reg_rdata_q <= offset_hi_q;
        synth_freq_pkg::ADDR_BAND:    reg_rdata_q <= band_q;
        synth_freq_pkg::ADDR_FRAC_HI: reg_rdata_q <= frac_hi_q;
        synth_freq_pkg::ADDR_FRAC_LO: reg_rdata_q <= frac_lo_q;
        synth_freq_pkg::ADDR_HOP_CH:  reg_rdata_q <= hop_ch_q;
        synth_freq_pkg::ADDR_HOP_STP: reg_rdata_q <= hop_stp_q;
        default:                      reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Nominal word in loop LSBs: integer, fraction, signed offset, hop
  always_comb
  begin
    base_word = 26'(band_q[4:0]) * 26'(synth_freq_pkg::FRAC_MOD)
              + 26'({frac_hi_q, frac_lo_q})
              + 26'(signed'({offset_hi_q[1:0], offset_lo_q}))
              + 26'(hop_ch_q) * 26'(hop_stp_q)
                * 26'(band_q[synth_freq_pkg::BAND_HB_BIT] ?
                      synth_freq_pkg::HOP_UNIT_HB :
                      synth_freq_pkg::HOP_UNIT_LB);
  end

  // Deviation steps the fraction per symbol while transmitting
  always_comb
  begin
    mod_word = word_q;
    if (state_q == synth_freq_pkg::ST_TX && fsk_enable)
    begin
      if (tx_symbol)
        mod_word = word_q + 26'(deviation_field) * 26'(
          band_q[synth_freq_pkg::BAND_HB_BIT] ?
          synth_freq_pkg::DEV_UNIT_HB : synth_freq_pkg::DEV_UNIT_LB);
      else
        mod_word = word_q - 26'(deviation_field) * 26'(
          band_q[synth_freq_pkg::BAND_HB_BIT] ?
          synth_freq_pkg::DEV_UNIT_HB : synth_freq_pkg::DEV_UNIT_LB);
    end
    pos_word = mod_word[25] ? 25'h000_0000 : mod_word[24:0];
    quot     = pos_word / synth_freq_pkg::FRAC_MOD;
  end

  // Split into integer ratio and fraction; integer carries offset 24
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      n_q <= synth_freq_pkg::N_OFFSET;
      f_q <= 16'h0000;
    end
    else
    begin
      n_q <= synth_freq_pkg::N_OFFSET + quot[7:0];
      f_q <= 16'(pos_word % synth_freq_pkg::FRAC_MOD);
    end
  end

  assign hop_wr = reg_wr && (reg_addr == synth_freq_pkg::ADDR_HOP_CH ||
                             reg_addr == synth_freq_pkg::ADDR_HOP_STP);
  // A packet in flight from the FIFO holds the old frequency
  assign retune = hop_pend_q && !(fifo_mode && packet_active);
  assign enter_cal =
    (state_q == synth_freq_pkg::ST_OFF && (synth_enable || tx_enable)) ||
    (state_q == synth_freq_pkg::ST_TX && tx_enable && retune);

  // Pending hop change; a new write wins over the clear
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      hop_pend_q <= 1'b0;
    else if (hop_wr && state_q == synth_freq_pkg::ST_TX)
      hop_pend_q <= 1'b1;
    else if (enter_cal || state_q == synth_freq_pkg::ST_OFF)
      hop_pend_q <= 1'b0;
  end

  // Word is captured only on entry to calibration
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      word_q <= '0;
    else if (enter_cal)
      word_q <= base_word;
  end

  // Sequencer: power-up calibration, then retunes on enable and on a hop change in TX
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q <= synth_freq_pkg::ST_CAL;
      cnt_q   <= 12'(synth_freq_pkg::CAL_CYC - 1);
    end
    else
    begin
      unique case (state_q)
        synth_freq_pkg::ST_OFF:
          if (enter_cal)
          begin
            state_q <= synth_freq_pkg::ST_CAL;
            cnt_q   <= 12'(synth_freq_pkg::CAL_CYC - 1);
          end
        synth_freq_pkg::ST_CAL:
          if (cnt_q == 12'h000)
          begin
            state_q <= synth_freq_pkg::ST_SETTLE;
            cnt_q   <= 12'(synth_freq_pkg::SETTLE_CYC - 1);
          end
          else
            cnt_q <= cnt_q - 12'h001;
        synth_freq_pkg::ST_SETTLE:
          if (cnt_q != 12'h000)
            cnt_q <= cnt_q - 12'h001;
          else if (tx_enable)
            state_q <= synth_freq_pkg::ST_TX;
          else if (synth_enable)
            state_q <= synth_freq_pkg::ST_TUNE;
          else
            state_q <= synth_freq_pkg::ST_OFF;
        synth_freq_pkg::ST_TUNE:
          if (tx_enable)
            state_q <= synth_freq_pkg::ST_TX;
          else if (!synth_enable)
            state_q <= synth_freq_pkg::ST_OFF;
        synth_freq_pkg::ST_TX:
          if (!tx_enable)
            state_q <= synth_enable ? synth_freq_pkg::ST_TUNE :
                                      synth_freq_pkg::ST_OFF;
          else if (retune)
          begin
            // Back through calibration and settling, then TX resumes
            state_q <= synth_freq_pkg::ST_CAL;
            cnt_q   <= 12'(synth_freq_pkg::CAL_CYC - 1);
          end
      endcase
    end
  end

  // Half-rate phase stands in for the 10 MHz reference tick
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      ref_ph_q <= 1'b0;
    else
      ref_ph_q <= !ref_ph_q;
  end

  assign sdm_bus.frac  = f_q;
  assign sdm_bus.int_n = n_q;
  assign sdm_bus.step  = ref_ph_q;
  assign sdm_bus.run   = (state_q == synth_freq_pkg::ST_SETTLE ||
                          state_q == synth_freq_pkg::ST_TUNE ||
                          state_q == synth_freq_pkg::ST_TX);

  sdm_mash3 #(
    .FRAC_W (16)
  ) u_sdm (
    .clk_sys (clk_sys),
    .srst    (srst),
    .bus     (sdm_bus.sdm)
  );

  // Status outputs, all registered
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      div_ratio_q <= 8'h00;
      band_high_q <= 1'b0;
      pll_on_q    <= 1'b0;
      vco_cal_q   <= 1'b0;
      tx_active_q <= 1'b0;
    end
    else
    begin
      div_ratio_q <= sdm_bus.div_n;
      band_high_q <= band_q[synth_freq_pkg::BAND_HB_BIT];
      pll_on_q    <= sdm_bus.run;
      vco_cal_q   <= (state_q == synth_freq_pkg::ST_CAL);
      tx_active_q <= (state_q == synth_freq_pkg::ST_TX);
    end
  end

  band_clamp_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_wr && reg_addr == synth_freq_pkg::ADDR_BAND &&
     reg_wdata[4:0] > 5'h17) |=> band_q[4:0] == 5'h17)
    else $error("band_integer not clamped to 23");

  cal_load_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q != synth_freq_pkg::ST_CAL ##1
     state_q == synth_freq_pkg::ST_CAL) |->
     cnt_q == 12'(synth_freq_pkg::CAL_CYC - 1))
    else $error("calibration count not loaded");

  cal_count_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == synth_freq_pkg::ST_CAL && cnt_q != 12'h000) |=>
    (state_q == synth_freq_pkg::ST_CAL && cnt_q == $past(cnt_q) - 12'h001))
    else $error("calibration count broken");

  hop_retune_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == synth_freq_pkg::ST_TX && tx_enable && hop_pend_q &&
     !(fifo_mode && packet_active)) |=> state_q == synth_freq_pkg::ST_CAL)
    else $error("hop change did not retune");

  hop_mark_a: assert property (@(posedge clk_sys) disable iff (srst)
    (hop_wr && state_q == synth_freq_pkg::ST_TX) |=> hop_pend_q)
    else $error("hop write in TX not recorded");

  packet_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == synth_freq_pkg::ST_TX && tx_enable && fifo_mode &&
     packet_active) |=> state_q == synth_freq_pkg::ST_TX)
    else $error("retune inside FIFO packet");

  tune_entry_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == synth_freq_pkg::ST_SETTLE && cnt_q == 12'h000 &&
     synth_enable && !tx_enable) |=> state_q == synth_freq_pkg::ST_TUNE)
    else $error("tune not entered after settling");

  word_latch_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == synth_freq_pkg::ST_OFF && (synth_enable || tx_enable)) |=>
    word_q == $past(base_word))
    else $error("word not captured on enable");

  frac_range_a: assert property (@(posedge clk_sys) disable iff (srst)
    (n_q >= 8'h18) && (32'(f_q) < 32'h0000_fa00))
    else $error("integer or fraction out of range");

endmodule

/* bench/host_model.sv */
// Host model that writes and reads the frequency registers
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk_sys,
  output logic            reg_wr,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_q
);
  // Idle bus: strobe low
  initial
  begin
    reg_wr    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
  end

  // One write, held until the taking edge; stale data is inverted
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #2;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // Read: address held two edges, data taken after the second
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #2;
    reg_addr = a;
    repeat (2) @(posedge clk_sys);
    #2;
    d = reg_rdata_q;
  endtask

  // Nominal first, step and channel last, so a hop has a known base
  task automatic prog(input logic [7:0] b, input logic [15:0] frac,
                      input logic [9:0] ofs, input logic [7:0] st,
                      input logic [7:0] ch);
    wr(7'h73, ofs[7:0]);
    wr(7'h74, {6'h00, ofs[9:8]});
    wr(7'h75, b);
    wr(7'h76, frac[15:8]);
    wr(7'h77, frac[7:0]);
    wr(7'h7a, st);
    wr(7'h79, ch);
  endtask
endmodule

/* bench/test_synth_frequency_control.sv */
// Self-checking bench for the synthesizer frequency control block
`timescale 1ns/10ps
module test_synth_frequency_control;
  logic       clk_sys;
  logic       srst;
  logic       reg_wr;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_q;
  logic       synth_enable;
  logic       tx_enable;
  logic       fifo_mode;
  logic       packet_active;
  logic       fsk_enable;
  logic       tx_symbol;
  logic [8:0] deviation_field;
  logic [7:0] div_ratio_q;
  logic       band_high_q;
  logic       pll_on_q;
  logic       vco_cal_q;
  logic       tx_active_q;
  int         mismatches;
  int         n_compared;
  int         cyc;
  int         n;

  synth_frequency_control i_synth_frequency_control (
    .clk_sys        (clk_sys),
    .srst           (srst),
    .reg_wr         (reg_wr),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_rdata_q    (reg_rdata_q),
    .synth_enable   (synth_enable),
    .tx_enable      (tx_enable),
    .fifo_mode      (fifo_mode),
    .packet_active  (packet_active),
    .fsk_enable     (fsk_enable),
    .tx_symbol      (tx_symbol),
    .deviation_field(deviation_field),
    .div_ratio_q    (div_ratio_q),
    .band_high_q    (band_high_q),
    .pll_on_q       (pll_on_q),
    .vco_cal_q      (vco_cal_q),
    .tx_active_q    (tx_active_q)
  );

  host_model i_host_model (
    .clk_sys    (clk_sys),
    .reg_wr     (reg_wr),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_rdata_q(reg_rdata_q)
  );

  // 20 MHz clock
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  task automatic test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk8(input string s, input logic [7:0] e,
                      input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s exp %0h got %0h", s, e, g);
    end
  endtask

  task automatic chk1(input string s, input logic e, input logic g);
    chk8(s, {7'h00, e}, {7'h00, g});
  endtask

  task automatic chk_num(input string s, input int e, input int g,
                         input int tol);
    n_compared++;
    if (g > e + tol || g < e - tol)
    begin
      mismatches++;
      $display("unexpected %s exp %0d got %0d", s, e, g);
    end
  endtask

  task automatic tick;
    @(posedge clk_sys);
    #2;
  endtask

  // Bounded wait for calibration (k=0) or transmit (k=1) to reach v
  task automatic wait_sig(input int k, input logic v, input int lim);
    n = 0;
    while ((k == 0 ? vco_cal_q : tx_active_q) !== v && n < lim)
    begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    chk1("reached", 1'b1, n < lim);
  endtask

  // Mean division over 4000 clocks; modulator residue stays small
  task automatic avg_chk(input int word);
    int sum;
    sum = 0;
    repeat (4000)
    begin
      @(posedge clk_sys);
      #2;
      sum += int'(div_ratio_q);
    end
    chk_num("mean_div", (24 * 64000 + word) / 16, sum, 16);
  endtask

  task automatic t_powerup;
    wait_sig(0, 1'b1, 10);
    wait_sig(0, 1'b0, 2100);
    chk_num("cal_len", 2000, n, 0);
    repeat (2010) tick;
  endtask

  // Reset values of every register and an unmapped hole
  task automatic t_regs;
    logic [6:0] a[8];
    logic [7:0] v[8];
    logic [7:0] d;
    a = '{7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h79, 7'h7a, 7'h78};
    v = '{8'h00, 8'h00, 8'h35, 8'hbb, 8'h80, 8'h00, 8'h00, 8'h00};
    i_host_model.wr(7'h78, 8'h5a);
    foreach (a[i])
    begin
      i_host_model.rd(a[i], d);
      chk8("reg_val", v[i], d);
    end
  endtask

  task automatic t_clamp;
    logic [7:0] d;
    i_host_model.wr(7'h75, 8'hff);
    i_host_model.rd(7'h75, d);
    chk8("band_sel", 8'h77, d);
    chk1("band_high", 1'b1, band_high_q);
    i_host_model.wr(7'h75, 8'h18);
    i_host_model.rd(7'h75, d);
    chk8("band_sel", 8'h17, d);
    chk1("band_high", 1'b0, band_high_q);
    i_host_model.wr(7'h74, 8'hff);
    i_host_model.rd(7'h74, d);
    chk8("offset_hi", 8'h03, d);
  endtask

  // Low band tune; a write while tuned waits for the next enable
  task automatic t_tune;
    i_host_model.prog(8'h03, 16'h7d00, 10'h000, 8'h02, 8'h03);
    synth_enable = 1'b1;
    repeat (4010) tick;
    chk1("pll_on", 1'b1, pll_on_q);
    chk1("tx_active", 1'b0, tx_active_q);
    avg_chk(224384);
    i_host_model.wr(7'h76, 8'h00);
    avg_chk(224384);
    synth_enable = 1'b0;
    repeat (5) tick;
    chk1("pll_on", 1'b0, pll_on_q);
    synth_enable = 1'b1;
    repeat (4010) tick;
    avg_chk(192384);
    synth_enable = 1'b0;
    repeat (5) tick;
  endtask

  // High band transmit with negative offset, hop and deviation
  task automatic t_tx;
    i_host_model.prog(8'h25, 16'h0000, 10'h3c0, 8'h64, 8'h05);
    tx_enable = 1'b1;
    wait_sig(1, 1'b1, 4100);
    chk1("band_high", 1'b1, band_high_q);
    avg_chk(335936);
    fsk_enable = 1'b1;
    tx_symbol = 1'b1;
    avg_chk(336136);
    tx_symbol = 1'b0;
    avg_chk(335736);
    fsk_enable = 1'b0;
  endtask

  task automatic t_hop;
    i_host_model.wr(7'h79, 8'h06);
    wait_sig(0, 1'b1, 5);
    chk1("tx_active", 1'b0, tx_active_q);
    wait_sig(1, 1'b1, 4100);
    avg_chk(339136);
  endtask

  // A step write in a FIFO packet must wait for the packet end
  task automatic t_fifo;
    fifo_mode = 1'b1;
    packet_active = 1'b1;
    i_host_model.wr(7'h7a, 8'h65);
    avg_chk(339136);
    chk1("cal_held", 1'b0, vco_cal_q);
    chk1("tx_active", 1'b1, tx_active_q);
    packet_active = 1'b0;
    wait_sig(0, 1'b1, 5);
    wait_sig(1, 1'b1, 4100);
    avg_chk(339328);
  endtask

  initial
  begin
    srst = 1'b1;
    synth_enable = 1'b0;
    tx_enable = 1'b0;
    fifo_mode = 1'b0;
    packet_active = 1'b0;
    fsk_enable = 1'b0;
    tx_symbol = 1'b0;
    deviation_field = 9'h064;
    mismatches = 0;
    n_compared = 0;
    repeat (20) tick;
    srst = 1'b0;
    t_powerup;
    t_regs;
    t_clamp;
    t_tune;
    t_tx;
    t_hop;
    t_fifo;
    test_done;
  end

  // Ceiling well above the roughly 60k cycles the run needs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      mismatches++;
      test_done;
    end
  end
endmodule
